// File: hdl/ffpec_pkg.sv
// Behaviour
// - Erase set-up: write 30H to command latch; no array change.
// - Second consecutive 30H write starts chip erase on write strobe rise.
// - Program set-up: write 10H or 50H, command only.
// - After timeout bit seen, host rereads the completion poll bit.
// - After timeout bit seen, host rereads the toggle status bit; the controller rechecks the poll and timeout bits, never the toggle bit.
// - After erase done host compares output against FFH.
// - Host may write read command 00H to mask an erased device.
// - Write needs output gate high, chip select and write strobe low.
// - Command latch defaults to read code 00H without high voltage.
// - After program set-up, reset code FFH written twice aborts.
package ffpec_pkg;
	localparam logic [7:0] CMD_READ = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] CMD_ERASE = 8'h30;
	localparam logic [7:0] CMD_PROG_A = 8'h10;
	localparam logic [7:0] CMD_PROG_B = 8'h50;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int FAIL_BIT = 5;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_RDAT = 8'h10;
	// Control register opcodes, written to bits [2:0]; writing one of these while idle starts the job, while opcode 6 or 7 sets the verify error bit instead
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_PROG = 3'h2;
	localparam logic [2:0] OP_ERASE = 3'h3;
	localparam logic [2:0] OP_RESET = 3'h4;
	localparam logic [2:0] OP_MASK = 3'h5;
	// Status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_VERR = 3;
	localparam int ST_VPP = 4;
	// Bus phase timing, in ns and derived cycles at 40 MHz
	localparam int CLK_NS = 25;
	localparam int SETUP_NS = 50;
	localparam int PULSE_NS = 100;
	localparam int HOLD_NS = 50;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
	localparam logic [3:0] PULSE_CNT = 4'(PULSE_CYC);
	localparam logic [3:0] HOLD_CNT = 4'(HOLD_CYC);
	localparam logic [31:0] POLL_LIMIT_DEF = 32'h0100_0000;

	typedef enum logic [3:0] {
		FFPEC_IDLE = 4'b0000,
		FFPEC_W_SETUP = 4'b0001,
		FFPEC_W_PULSE = 4'b0010,
		FFPEC_W_HOLD = 4'b0011,
		FFPEC_R_SETUP = 4'b0100,
		FFPEC_R_PULSE = 4'b0101,
		FFPEC_R_HOLD = 4'b0110,
		FFPEC_NEXT = 4'b0111
	} ffpec_bus_e;

	typedef enum logic [2:0] {
		FFPEC_J_NONE = 3'b000,
		FFPEC_J_CMD2 = 3'b001,
		FFPEC_J_POLL = 3'b010,
		FFPEC_J_RECHK = 3'b011,
		FFPEC_J_VERIFY = 3'b100,
		FFPEC_J_FIN = 3'b101
	} ffpec_job_e;
endpackage

// File: hdl/ffpec_ctrl.sv
`timescale 1ns/10ps
module ffpec_ctrl import ffpec_pkg::*; #(
	parameter int ADDR_W = 15,
	parameter logic [31:0] POLL_LIMIT = POLL_LIMIT_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash pins
	output logic [ADDR_W-1:0] fl_addr,
	input wire logic [7:0] fl_dq_in,
	output logic [7:0] fl_dq_out,
	output logic fl_dq_oe_n,
	output logic fl_ce_n,
	output logic fl_we_n,
	output logic fl_oe_n,
	output logic fl_vpp_en
);
	typedef struct packed {
		ffpec_bus_e bus;
		ffpec_job_e job;
		logic [2:0] op;
		logic [3:0] cnt;
		logic [31:0] polls;
		logic [7:0] wbyte;
		logic second;
		logic [ADDR_W-1:0] addr_reg;
		logic [7:0] data_reg;
		logic [7:0] last;
		logic [7:0] rd;
		logic busy, done, fail, verr, vpp;
		logic [31:0] prdata;
		logic pready, pslverr;
		logic [ADDR_W-1:0] fa;
		logic [7:0] fd;
		logic dq_oe_n, ce_n, we_n, oe_n;
	} ffpec_st_s;

	ffpec_st_s st_ff;
	ffpec_st_s nxt_st;
	logic acc;
	logic [7:0] sample;

	assign acc = psel & penable & ~st_ff.pready;
	assign sample = fl_dq_in;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.pready = 1'b0;
		nxt_st.pslverr = 1'b0;
		// APB register access; answer one cycle after the access phase starts
		if (acc) begin
			nxt_st.pready = 1'b1;
			nxt_st.prdata = 32'h0000_0000;
			if (pwrite) begin
				case (paddr)
					REG_CTRL: begin
						if (st_ff.busy) begin
							nxt_st.pslverr = 1'b1;
						end else begin
							nxt_st.op = pwdata[2:0];
							nxt_st.vpp = pwdata[8];
							nxt_st.done = 1'b0;
							nxt_st.verr = 1'b0;
							if (pwdata[2:0] != 3'h0) begin
								nxt_st.busy = 1'b1;
								nxt_st.fail = 1'b0;
								nxt_st.second = 1'b0;
								nxt_st.polls = 32'h0000_0000;
							end
						end
					end
					REG_ADDR: nxt_st.addr_reg = pwdata[ADDR_W-1:0];
					REG_DATA: nxt_st.data_reg = pwdata[7:0];
					default: nxt_st.pslverr = 1'b1;
				endcase
			end else begin
				case (paddr)
					REG_CTRL: nxt_st.prdata = {23'h0, st_ff.vpp, 5'h0, st_ff.op};
					REG_ADDR: nxt_st.prdata = 32'(st_ff.addr_reg);
					REG_DATA: nxt_st.prdata = {24'h0, st_ff.data_reg};
					REG_STAT: nxt_st.prdata = {27'h0, st_ff.vpp, st_ff.verr, st_ff.fail, st_ff.done, st_ff.busy};
					REG_RDAT: nxt_st.prdata = {24'h0, st_ff.rd};
					default: nxt_st.pslverr = 1'b1;
				endcase
			end
		end
		if (st_ff.cnt != 4'h0) begin
			nxt_st.cnt = st_ff.cnt - 4'h1;
		end
		case (st_ff.bus)
			FFPEC_IDLE: begin
				if (st_ff.busy && st_ff.cnt == 4'h0) begin
					nxt_st.job = FFPEC_J_NONE;
					nxt_st.fa = st_ff.addr_reg;
					nxt_st.cnt = SETUP_CNT;
					case (st_ff.op)
						OP_READ: begin
							nxt_st.bus = FFPEC_R_SETUP;
							nxt_st.job = FFPEC_J_FIN;
						end
						OP_PROG: begin
							nxt_st.wbyte = CMD_PROG_A;
							nxt_st.job = FFPEC_J_CMD2;
							nxt_st.bus = FFPEC_W_SETUP;
						end
						OP_ERASE: begin
							nxt_st.wbyte = CMD_ERASE;
							nxt_st.job = FFPEC_J_CMD2;
							nxt_st.bus = FFPEC_W_SETUP;
						end
						OP_RESET: begin
							nxt_st.wbyte = CMD_RESET;
							nxt_st.job = FFPEC_J_CMD2;
							nxt_st.bus = FFPEC_W_SETUP;
						end
						OP_MASK: begin
							nxt_st.wbyte = CMD_READ;
							nxt_st.job = FFPEC_J_NONE;
							nxt_st.bus = FFPEC_W_SETUP;
						end
						default: begin
							nxt_st.busy = 1'b0;
							nxt_st.verr = 1'b1;
						end
					endcase
				end
			end
			// Write cycle: output gate high before chip select and strobe fall
			FFPEC_W_SETUP: begin
				nxt_st.oe_n = 1'b1;
				nxt_st.fd = st_ff.wbyte;
				nxt_st.dq_oe_n = 1'b0;
				if (st_ff.cnt == 4'h0) begin
					nxt_st.ce_n = 1'b0;
					nxt_st.we_n = 1'b0;
					nxt_st.cnt = PULSE_CNT;
					nxt_st.bus = FFPEC_W_PULSE;
				end
			end
			FFPEC_W_PULSE: begin
				if (st_ff.cnt == 4'h0) begin
					// Both rise together so the strobe edge starts the operation
					nxt_st.we_n = 1'b1;
					nxt_st.ce_n = 1'b1;
					nxt_st.cnt = HOLD_CNT;
					nxt_st.bus = FFPEC_W_HOLD;
				end
			end
			FFPEC_W_HOLD: begin
				if (st_ff.cnt == 4'h0) begin
					nxt_st.dq_oe_n = 1'b1;
					nxt_st.bus = FFPEC_NEXT;
				end
			end
			FFPEC_R_SETUP: begin
				nxt_st.dq_oe_n = 1'b1;
				if (st_ff.cnt == 4'h0) begin
					nxt_st.ce_n = 1'b0;
					nxt_st.oe_n = 1'b0;
					nxt_st.cnt = PULSE_CNT;
					nxt_st.bus = FFPEC_R_PULSE;
				end
			end
			FFPEC_R_PULSE: begin
				if (st_ff.cnt == 4'h0) begin
					nxt_st.rd = sample;
					nxt_st.last = sample;
					nxt_st.ce_n = 1'b1;
					nxt_st.oe_n = 1'b1;
					nxt_st.cnt = HOLD_CNT;
					nxt_st.bus = FFPEC_R_HOLD;
				end
			end
			FFPEC_R_HOLD: begin
				if (st_ff.cnt == 4'h0) begin
					nxt_st.bus = FFPEC_NEXT;
				end
			end
			FFPEC_NEXT: begin
				nxt_st.bus = FFPEC_IDLE;
				nxt_st.cnt = SETUP_CNT;
				case (st_ff.job)
					FFPEC_J_CMD2: begin
						// Second write of the two-write sequence
						nxt_st.job = FFPEC_J_POLL;
						nxt_st.bus = FFPEC_W_SETUP;
						if (st_ff.op == OP_PROG) begin
							nxt_st.wbyte = st_ff.data_reg;
						end else if (st_ff.op == OP_RESET) begin
							nxt_st.wbyte = CMD_RESET;
							nxt_st.job = FFPEC_J_NONE;
						end else begin
							nxt_st.wbyte = CMD_ERASE;
						end
					end
					FFPEC_J_POLL: begin
						// Polling only after the second strobe has risen
						nxt_st.bus = FFPEC_R_SETUP;
						nxt_st.job = FFPEC_J_RECHK;
						nxt_st.polls = st_ff.polls + 32'h1;
					end
					FFPEC_J_RECHK: begin
						if ((st_ff.op == OP_ERASE && st_ff.last[POLL_BIT]) ||
							(st_ff.op == OP_PROG && st_ff.last[POLL_BIT] == st_ff.data_reg[POLL_BIT])) begin
							// Completion: next read returns valid data
							nxt_st.bus = FFPEC_R_SETUP;
							nxt_st.job = FFPEC_J_VERIFY;
						end else if (st_ff.last[FAIL_BIT]) begin
							// Poll bit may change with or after the fail bit
							if (st_ff.fail) begin
								nxt_st.busy = 1'b0;
								nxt_st.done = 1'b1;
								nxt_st.bus = FFPEC_IDLE;
								nxt_st.job = FFPEC_J_NONE;
							end else begin
								nxt_st.fail = 1'b1;
								nxt_st.bus = FFPEC_R_SETUP;
							end
						end else if (st_ff.polls >= POLL_LIMIT) begin
							nxt_st.fail = 1'b1;
							nxt_st.busy = 1'b0;
							nxt_st.done = 1'b1;
							nxt_st.bus = FFPEC_IDLE;
							nxt_st.job = FFPEC_J_NONE;
						end else begin
							nxt_st.bus = FFPEC_R_SETUP;
							nxt_st.polls = st_ff.polls + 32'h1;
						end
					end
					FFPEC_J_VERIFY: begin
						nxt_st.busy = 1'b0;
						nxt_st.done = 1'b1;
						nxt_st.job = FFPEC_J_NONE;
						if (st_ff.op == OP_ERASE) begin
							nxt_st.verr = (st_ff.last != ERASED_BYTE);
						end else begin
							nxt_st.verr = (st_ff.last != st_ff.data_reg);
						end
					end
					default: begin
						nxt_st.busy = 1'b0;
						nxt_st.done = 1'b1;
						nxt_st.job = FFPEC_J_NONE;
					end
				endcase
			end
			default: nxt_st.bus = FFPEC_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.bus <= FFPEC_IDLE;
			st_ff.job <= FFPEC_J_NONE;
			st_ff.dq_oe_n <= 1'b1;
			st_ff.ce_n <= 1'b1;
			st_ff.we_n <= 1'b1;
			st_ff.oe_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign fl_addr = st_ff.fa;
	assign fl_dq_out = st_ff.fd;
	assign fl_dq_oe_n = st_ff.dq_oe_n;
	assign fl_ce_n = st_ff.ce_n;
	assign fl_we_n = st_ff.we_n;
	assign fl_oe_n = st_ff.oe_n;
	assign fl_vpp_en = st_ff.vpp;
endmodule

// File: test/ffpec_ctrl_sva.sv
`timescale 1ns/10ps
module ffpec_ctrl_sva import ffpec_pkg::*; #(
	parameter int ADDR_W = 15
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Flash pins
	input wire logic [ADDR_W-1:0] fl_addr,
	input wire logic [7:0] fl_dq_out,
	input wire logic fl_dq_oe_n,
	input wire logic fl_ce_n,
	input wire logic fl_we_n,
	input wire logic fl_oe_n,
	input wire logic fl_vpp_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready not one wait state");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	a_err_pair: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_write_pins: assert property (!fl_we_n |-> fl_oe_n && !fl_ce_n) else $error("bad write pins");
	a_write_vpp: assert property (!fl_we_n |-> fl_vpp_en) else $error("write without vpp");
	a_no_clash: assert property (!fl_oe_n |-> fl_dq_oe_n) else $error("bus contention on read");
	a_write_stable: assert property (!fl_we_n |-> !fl_dq_oe_n && $stable(fl_addr) && $stable(fl_dq_out))
		else $error("address or data moved in write");
	a_we_len: assert property ($fell(fl_we_n) |-> !fl_we_n[*5] ##1 fl_we_n) else $error("write pulse length");
	a_data_hold: assert property ($rose(fl_we_n) |=> !fl_dq_oe_n && $stable(fl_dq_out)) else $error("no data hold");
	a_oe_len: assert property ($fell(fl_oe_n) |-> !fl_oe_n[*5] ##1 fl_oe_n) else $error("read pulse length");
	c_write: cover property ($rose(fl_we_n));
	c_read: cover property ($rose(fl_oe_n));
	c_refuse: cover property (pslverr);
endmodule

// File: test/ffpec_flash_model.sv
`timescale 1ns/10ps
module ffpec_flash_model (
	// Flash pins
	input wire logic [14:0] addr,
	input wire logic [7:0] din,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic vpp,
	output logic [7:0] dout,
	// Fault injection
	input wire logic fault_en
);
	logic [7:0] mem [0:32767];
	logic [7:0] wlog [$];
	logic [7:0] pd;
	logic [14:0] pa;
	logic [2:0] st = 3'h0;
	logic tog = 1'b0;
	logic sel = 1'b0;
	int left = 0;
	int nfr = 0;
	initial foreach (mem[i]) mem[i] = 8'hFF;
	initial dout = 8'h00;
	// Strobes fall in one time step in any order; act once both are low
	always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) begin
		pa = addr;
		sel = oe_n && vpp;
	end
	always @(posedge we_n or posedge ce_n) if (sel) begin
		sel = 1'b0;
		wlog.push_back(din);
		pd = din;
		left = 3;
		case (st)
			3'h0: st = (din == 8'h30) ? 3'h2 : (din == 8'h10 || din == 8'h50) ? 3'h1 : 3'h0;
			3'h1: st = 3'h3;
			3'h2: st = (din == 8'h30) ? 3'h4 : 3'h0;
			default: st = 3'h0;
		endcase
	end
	always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n) begin
		if (st != 3'h0) begin
			dout = {(st == 3'h3) ? ~pd[7] : 1'b0, tog, fault_en && st > 3'h2, 5'h00};
			tog = ~tog;
			nfr += int'(fault_en);
			// A fault leaves the job stuck with only status reads working
			if (st > 3'h2 && !fault_en && --left == 0) begin
				if (st == 3'h3) mem[pa] = mem[pa] & pd;
				else begin
					foreach (mem[i]) mem[i] = 8'h00;
					foreach (mem[i]) mem[i] = 8'hFF;
				end
				st = 3'h0;
			end
		end else dout = mem[addr];
	end
	// Released bus shows the inverse so a late sample cannot pass
	always @(posedge oe_n) dout = ~dout;
endmodule

// File: test/ffpec_ctrl_bench.sv
`timescale 1ns/10ps
module ffpec_ctrl_bench;
	import ffpec_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault_en = 0, e, pready, pslverr;
	logic fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_vpp_en;
	logic [7:0] paddr = 0, fl_dq_in, fl_dq_out;
	logic [31:0] pwdata = 0, prdata, r;
	logic [14:0] fl_addr;
	int fail_count = 0, n_compared = 0, cyc = 0, w0;
	always #12.5 pclk = ~pclk;
	ffpec_ctrl #(.POLL_LIMIT(32'h0000_0010)) ffpec_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out),
		.fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_vpp_en(fl_vpp_en));
	ffpec_flash_model ffpec_flash_model_i (.addr(fl_addr), .din(fl_dq_out), .ce_n(fl_ce_n), .we_n(fl_we_n),
		.oe_n(fl_oe_n), .vpp(fl_vpp_en), .dout(fl_dq_in), .fault_en(fault_en));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("compared=%0d mismatches=%0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Polls status until the job is over; leaves STAT in r
	task wait_idle;
		for (int i = 0; i < 100; i++) begin
			apb(0, REG_STAT, 0);
			if (r[ST_BUSY] === 1'b0) break;
		end
	endtask
	task job(input logic [31:0] ctl, input int n, input logic [7:0] last, input logic [31:0] rd);
		w0 = ffpec_flash_model_i.wlog.size();
		apb(1, REG_CTRL, ctl);
		wait_idle;
		chk(r, 32'h0000_0012);
		chk(ffpec_flash_model_i.wlog.size() - w0, n);
		chk(ffpec_flash_model_i.wlog[$], last);
		apb(0, REG_RDAT, 0);
		chk(r, rd);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			stop_test;
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, REG_STAT, 0);
		chk(r, 32'h0000_0000);
		apb(0, 8'h20, 0);
		chk(e, 1'b1);
		apb(1, REG_ADDR, 32'h0000_1234);
		apb(1, REG_DATA, 32'h0000_005A);
		w0 = ffpec_flash_model_i.wlog.size();
		apb(1, REG_CTRL, 32'h0000_0102);
		apb(1, REG_CTRL, 32'h0000_0103);
		chk(e, 1'b1);
		wait_idle;
		chk(r, 32'h0000_0012);
		chk(ffpec_flash_model_i.wlog[w0], 8'h10);
		chk(ffpec_flash_model_i.wlog[w0+1], 8'h5A);
		chk(ffpec_flash_model_i.mem[15'h1234], 8'h5A);
		apb(0, REG_RDAT, 0);
		chk(r, 32'h0000_005A);
		job(32'h0000_0103, 2, 8'h30, 32'h0000_00FF);
		chk(ffpec_flash_model_i.mem[15'h1234], 8'hFF);
		job(32'h0000_0101, 0, 8'h30, 32'h0000_00FF);
		job(32'h0000_0104, 2, 8'hFF, 32'h0000_00FF);
		job(32'h0000_0105, 1, 8'h00, 32'h0000_00FF);
		fault_en <= 1;
		apb(1, REG_CTRL, 32'h0000_0102);
		wait_idle;
		chk(r[ST_FAIL], 1'b1);
		chk(ffpec_flash_model_i.nfr, 2);
		chk(r, 32'h0000_0016);
		apb(1, REG_CTRL, 32'h0000_0107);
		wait_idle;
		chk(r, 32'h0000_0018);
		chk(fl_vpp_en, 1'b1);
		stop_test;
	end
endmodule
bind ffpec_ctrl ffpec_ctrl_sva #(.ADDR_W(ADDR_W)) ffpec_ctrl_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
	.fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_vpp_en(fl_vpp_en));
